// >>> rtl/ivp_controller.sv
// Interrupt priority and vector selection for the processor core.
`include "ivp_consts.svh"
`default_nettype none
module ivp_controller (
   // Clock and synchronous active-low reset.
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   // Event pulses from the core and the peripherals, already on this clock.
   input wire ivp_pkg::ivp_events_type events_in,
   // Load strobes for the table base and the peripheral levels.
   input wire logic base_load_in,
   input wire ivp_pkg::ivp_addr_type base_value_in,
   input wire logic level_load_in,
   input wire logic [`IVP_NUM_PERIPH*`IVP_LVL_W-1:0] level_value_in,
   // Acknowledge from the core, naming the vector that it has taken.
   input wire logic ack_in,
   input wire ivp_pkg::ivp_vec_type ack_vector_in,
   // Registered request and reset entry addresses toward the core.
   output ivp_pkg::ivp_request_type request_out,
   output ivp_pkg::ivp_addr_type chip_reset_addr_out,
   output ivp_pkg::ivp_addr_type watchdog_reset_addr_out
);
   ivp_pkg::ivp_addr_type vector_table_base;
   logic [`IVP_NUM_PERIPH*`IVP_LVL_W-1:0] periph_level;
   logic [`IVP_NUM_VEC-1:0] pending;
   logic [`IVP_NUM_VEC-1:0] raw_event;
   logic [`IVP_NUM_VEC-1:0] clear_mask;
   logic [`IVP_NUM_VEC*`IVP_LVL_W-1:0] vec_level;
   logic win_found;
   ivp_pkg::ivp_vec_type win_vector;
   ivp_pkg::ivp_lvl_type win_level;
   ivp_pkg::ivp_addr_type next_fetch_addr;
   logic clock_loss_req;
   logic pwm_req;
   logic [2:0] cmp_req;
   ivp_pkg::ivp_addr_type vector_offset;

   ////////////////////////////////////////////////////////////////////////////
   // Table base; its reset value makes entries 0 and 1 overlay the reset addresses.
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         vector_table_base <= `IVP_BASE_RESET;
      end else if (base_load_in) begin
         vector_table_base <= base_value_in;
      end
   end

   // Per-peripheral levels, two bits each, starting at level 0.
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         periph_level <= `IVP_PERIPH_LEVEL_RESET;
      end else if (level_load_in) begin
         periph_level <= level_value_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sources that share one vector are ORed each cycle, so either event alone sets its flag.
   assign clock_loss_req = events_in.pll_lock_loss | events_in.pll_clock_loss;
   assign pwm_req = events_in.pwm_reload | events_in.pwm_fault;

   // Each comparator folds its rising and falling flags into one request of its own.
   genvar gc;
   generate
      for (gc = 0; gc < 3; gc++) begin : g_cmp
         assign cmp_req[gc] = events_in.cmp_rise[gc] | events_in.cmp_fall[gc];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Map the source events onto vector positions; entries 0 and 1 never request.
   always_comb begin
      raw_event = '0;
      raw_event[`IVP_VEC_LAST_CORE:`IVP_VEC_FIRST_CORE] = events_in.core_exc;
      raw_event[`IVP_VEC_LOW_VOLTAGE] = events_in.low_voltage;
      raw_event[`IVP_VEC_CLOCK_LOSS] = clock_loss_req;
      raw_event[`IVP_VEC_CONV_A] = events_in.conv_a_done;
      raw_event[`IVP_VEC_CONV_B] = events_in.conv_b_done;
      raw_event[`IVP_VEC_PWM] = pwm_req;
      raw_event[`IVP_VEC_CMP_FIRST +: 3] = cmp_req;
      raw_event[`IVP_VEC_FLASH] = events_in.flash_status;
      raw_event[`IVP_VEC_SPI_RX] = events_in.spi_rx_full;
      raw_event[`IVP_VEC_SPI_TX] = events_in.spi_tx_empty;
      raw_event[`IVP_VEC_SERIAL_COMM_PORT_TX] = events_in.serial_comm_port_tx_empty;
      raw_event[`IVP_VEC_SERIAL_COMM_PORT_RX] = events_in.serial_comm_port_rx_full;
      raw_event[`IVP_VEC_I2C] = events_in.i2c_event;
      raw_event[`IVP_VEC_INTERVAL] = events_in.interval_timer;
      raw_event[`IVP_VEC_TIMER_FIRST +: 2] = events_in.timer_ch;
      raw_event[`IVP_VEC_GPIO_FIRST +: 6] = events_in.gpio_port;
      raw_event[`IVP_VEC_RTC] = events_in.rtc_event;
      raw_event[1:0] = 2'h0;
   end

   // Core entries sit at fixed level 3, peripherals at their programmed level, entries 0 and 1 at fixed level 0.
   genvar gv;
   generate
      for (gv = 0; gv < `IVP_NUM_VEC; gv++) begin : g_level
         if (gv >= `IVP_VEC_FIRST_PERIPH) begin : g_periph
            assign vec_level[gv*`IVP_LVL_W +: `IVP_LVL_W] =
               periph_level[(gv-`IVP_VEC_FIRST_PERIPH)*`IVP_LVL_W +: `IVP_LVL_W];
         end else if (gv >= `IVP_VEC_FIRST_CORE) begin : g_core
            assign vec_level[gv*`IVP_LVL_W +: `IVP_LVL_W] = `IVP_CORE_LEVEL;
         end else begin : g_reserved
            assign vec_level[gv*`IVP_LVL_W +: `IVP_LVL_W] = '0;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Acknowledge clears one pending flag; a new event in that cycle wins.
   always_comb begin
      clear_mask = '0;
      if (ack_in && (ack_vector_in < `IVP_VEC_W'(`IVP_NUM_VEC))) begin
         clear_mask[ack_vector_in] = 1'b1;
      end
   end

   // Sticky pending flags, one per vector.
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         pending <= '0;
      end else begin
         pending <= (pending & ~clear_mask) | raw_event;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Ranking of the pending flags.
   ivp_arbiter u_arbiter (
      .pending_in(pending),
      .levels_in(vec_level),
      .found_out(win_found),
      .vector_out(win_vector),
      .level_out(win_level)
   );

   // Table offset of the winning vector: two words per entry, so twice its number.
   assign vector_offset = {{(`IVP_ADDR_W-`IVP_VEC_W-1){1'b0}}, win_vector, 1'b0};

   // Fetch address; a base near the top of the space wraps instead of saturating.
   assign next_fetch_addr = vector_table_base + vector_offset;

   // Registered request toward the core; it follows the pending set each cycle.
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         request_out <= '0;
      end else begin
         request_out.valid <= win_found;
         request_out.vector <= win_vector;
         request_out.level <= win_level;
         request_out.fetch_addr <= next_fetch_addr;
      end
   end

   // Reset fetch addresses for the chip reset and watchdog reset entries.
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         chip_reset_addr_out <= `IVP_BASE_RESET;
         watchdog_reset_addr_out <= `IVP_BASE_RESET;
      end else begin
         chip_reset_addr_out <= vector_table_base + `IVP_OFS_CHIP_RESET;
         watchdog_reset_addr_out <= vector_table_base + `IVP_OFS_WATCHDOG_RESET;
      end
   end
endmodule : ivp_controller
`default_nettype wire

// >>> include/ivp_consts.svh
// Constants of the interrupt vector priority block.
`ifndef IVP_CONSTS_SVH
`define IVP_CONSTS_SVH
`define IVP_ADDR_W 21
`define IVP_VEC_W 6
`define IVP_NUM_VEC 34
`define IVP_LVL_W 2
`define IVP_NUM_LVL 4
`define IVP_NUM_PERIPH 24
`define IVP_CORE_LEVEL 2'h3
`define IVP_PERIPH_LEVEL_RESET 48'h0
`define IVP_BASE_RESET 21'h000000
`define IVP_OFS_CHIP_RESET 21'h000000
`define IVP_OFS_WATCHDOG_RESET 21'h000002
`define IVP_VEC_FIRST_CORE 6'h02
`define IVP_VEC_LAST_CORE 6'h09
`define IVP_VEC_FIRST_PERIPH 6'h0a
`define IVP_VEC_LOW_VOLTAGE 6'h0a
`define IVP_VEC_CLOCK_LOSS 6'h0b
`define IVP_VEC_CONV_A 6'h0c
`define IVP_VEC_CONV_B 6'h0d
`define IVP_VEC_PWM 6'h0e
`define IVP_VEC_CMP_FIRST 6'h0f
`define IVP_VEC_FLASH 6'h12
`define IVP_VEC_SPI_RX 6'h13
`define IVP_VEC_SPI_TX 6'h14
`define IVP_VEC_SERIAL_COMM_PORT_TX 6'h15
`define IVP_VEC_SERIAL_COMM_PORT_RX 6'h16
`define IVP_VEC_I2C 6'h17
`define IVP_VEC_INTERVAL 6'h18
`define IVP_VEC_TIMER_FIRST 6'h19
`define IVP_VEC_GPIO_FIRST 6'h1b
`define IVP_VEC_RTC 6'h21
`endif

// >>> include/ivp_pkg.sv
// Types shared by the interrupt vector priority block.
`include "ivp_consts.svh"
`default_nettype none
package ivp_pkg;
   typedef logic [`IVP_VEC_W-1:0] ivp_vec_type;
   typedef logic [`IVP_LVL_W-1:0] ivp_lvl_type;
   typedef logic [`IVP_ADDR_W-1:0] ivp_addr_type;

   // One-cycle event pulses from the core and the peripherals.
   typedef struct packed {
      logic [7:0] core_exc;
      logic low_voltage;
      logic pll_lock_loss;
      logic pll_clock_loss;
      logic conv_a_done;
      logic conv_b_done;
      logic pwm_reload;
      logic pwm_fault;
      logic [2:0] cmp_rise;
      logic [2:0] cmp_fall;
      logic flash_status;
      logic spi_rx_full;
      logic spi_tx_empty;
      logic serial_comm_port_tx_empty;
      logic serial_comm_port_rx_full;
      logic i2c_event;
      logic interval_timer;
      logic [1:0] timer_ch;
      logic [5:0] gpio_port;
      logic rtc_event;
   } ivp_events_type;

   // Request presented to the core.
   typedef struct packed {
      logic valid;
      ivp_vec_type vector;
      ivp_lvl_type level;
      ivp_addr_type fetch_addr;
   } ivp_request_type;
endpackage : ivp_pkg
`default_nettype wire

// >>> rtl/ivp_arbiter.sv
// Picks the highest level, then the lowest vector, among pending requests.
`include "ivp_consts.svh"
`default_nettype none
module ivp_arbiter (
   input wire logic [`IVP_NUM_VEC-1:0] pending_in,
   input wire logic [`IVP_NUM_VEC*`IVP_LVL_W-1:0] levels_in,
   output logic found_out,
   output ivp_pkg::ivp_vec_type vector_out,
   output ivp_pkg::ivp_lvl_type level_out
);
   logic [`IVP_NUM_VEC-1:0] hit [`IVP_NUM_LVL];
   logic [`IVP_NUM_VEC-1:0] chosen;

   ////////////////////////////////////////////////////////////////////////////
   // Sort each pending vector into the row of its level.
   genvar gl, gv;
   generate
      for (gl = 0; gl < `IVP_NUM_LVL; gl++) begin : g_lvl
         for (gv = 0; gv < `IVP_NUM_VEC; gv++) begin : g_vec
            assign hit[gl][gv] = pending_in[gv] &&
               (levels_in[gv*`IVP_LVL_W +: `IVP_LVL_W] == `IVP_LVL_W'(gl));
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Highest occupied level wins, then the lowest vector in that level.
   always_comb begin
      found_out = 1'b0;
      level_out = '0;
      chosen = '0;
      vector_out = '0;
      for (int l = 0; l < `IVP_NUM_LVL; l++) begin
         if (|hit[l]) begin
            found_out = 1'b1;
            level_out = l[`IVP_LVL_W-1:0];
            chosen = hit[l];
         end
      end
      for (int v = `IVP_NUM_VEC - 1; v >= 0; v--) begin
         if (chosen[v]) begin
            vector_out = v[`IVP_VEC_W-1:0];
         end
      end
   end
endmodule : ivp_arbiter
`default_nettype wire

// >>> testbench/ivp_controller_assertions.sv
// Port assertions for the vector priority controller.
`default_nettype none
module ivp_controller_assertions (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire ivp_pkg::ivp_events_type events_in,
   input wire logic base_load_in,
   input wire ivp_pkg::ivp_addr_type base_value_in,
   input wire logic level_load_in,
   input wire logic [47:0] level_value_in,
   input wire logic ack_in,
   input wire ivp_pkg::ivp_vec_type ack_vector_in,
   input wire ivp_pkg::ivp_request_type request_out,
   input wire ivp_pkg::ivp_addr_type chip_reset_addr_out,
   input wire ivp_pkg::ivp_addr_type watchdog_reset_addr_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [47:0] lvl_copy;
   logic [47:0] lvl_seen;
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_b_in);
   // Mirrors the loaded levels, delayed to line up with the registered request.
   always_ff @(posedge core_clk_in) begin
      lvl_copy <= !rst_b_in ? '0 : level_load_in ? level_value_in : lvl_copy;
      lvl_seen <= lvl_copy;
   end
   sequence s_ack_timer;
      ack_in && ack_vector_in == 6'h19 && !events_in.timer_ch[0];
   endsequence
   a_reset_clear: assert property (disable iff (1'b0) !rst_b_in |=> request_out == '0 &&
      chip_reset_addr_out == '0 && watchdog_reset_addr_out == '0) else $error("outputs not cleared by reset");
   a_core_level: assert property (request_out.valid && request_out.vector <= 6'h09 |-> request_out.level == 2'h3)
      else $error("core exception not at level three");
   a_fetch_offset: assert property (request_out.valid |-> request_out.fetch_addr ==
      chip_reset_addr_out + ivp_pkg::ivp_addr_type'({request_out.vector, 1'b0})) else $error("bad fetch address");
   a_watchdog_gap: assert property ($past(rst_b_in) && $past(rst_b_in, 2) |->
      watchdog_reset_addr_out == chip_reset_addr_out + 21'h000002) else $error("watchdog entry misplaced");
   a_no_reserved: assert property (request_out.valid |-> request_out.vector inside {[6'h02:6'h21]})
      else $error("reserved vector presented");
   a_exc_latency: assert property (events_in.core_exc[0] |-> ##2 request_out.valid && request_out.vector == 6'h02)
      else $error("top exception not presented");
   a_ack_clears: assert property (s_ack_timer |-> ##2 !(request_out.valid && request_out.vector == 6'h19))
      else $error("acknowledged vector still presented");
   a_base_follow: assert property (base_load_in |-> ##2 chip_reset_addr_out == $past(base_value_in, 2))
      else $error("table base not applied");
   a_level_match: assert property (request_out.valid && request_out.vector >= 6'h0a |->
      request_out.level == lvl_seen[2*(request_out.vector-6'h0a) +: 2]) else $error("wrong level presented");
endmodule : ivp_controller_assertions
`default_nettype wire

// >>> testbench/ivp_core_model.sv
// Behavioural processor core that acknowledges each presented vector.
`default_nettype none
module ivp_core_model (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire ivp_pkg::ivp_request_type request_in,
   input wire logic enable_in,
   input wire logic [3:0] delay_in,
   output logic ack_out,
   output ivp_pkg::ivp_vec_type ack_vector_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_count = 4'h0;
   logic held = 1'b0;
   initial ack_out = 1'b0;
   initial ack_vector_out = '0;
   // Acks after the chosen delay, then skips two edges while the stale request drains.
   always @(posedge clk_in) begin
      held <= ack_out;
      ack_out <= 1'b0;
      ack_vector_out <= ~ack_vector_out; // An idle vector line never holds its last value.
      // Entries 0 and 1 hold jumps reached only through reset, so they are never taken as calls.
      if (!rst_b_in || !enable_in || !request_in.valid || ack_out || held || request_in.vector < 6'h02)
         wait_count <= 4'h0;
      else if (wait_count >= delay_in) begin
         ack_out <= 1'b1;
         ack_vector_out <= request_in.vector;
      end else
         wait_count <= wait_count + 4'h1;
   end
endmodule : ivp_core_model
`default_nettype wire

// >>> testbench/test_ivp_controller.sv
// Self-checking testbench of the vector priority controller.
`default_nettype none
module test_ivp_controller;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   ivp_pkg::ivp_events_type events_in = '0;
   logic base_load_in = 1'b0;
   ivp_pkg::ivp_addr_type base_value_in = '0;
   logic level_load_in = 1'b0;
   logic [47:0] level_value_in = '0;
   logic ack_in;
   ivp_pkg::ivp_vec_type ack_vector_in;
   ivp_pkg::ivp_request_type request_out;
   ivp_pkg::ivp_addr_type chip_reset_addr_out;
   ivp_pkg::ivp_addr_type watchdog_reset_addr_out;
   logic core_enable = 1'b0;
   logic [3:0] core_delay = 4'h0;
   int failures = 0;
   int samples_checked = 0;
   ivp_pkg::ivp_vec_type served[$];
   ivp_pkg::ivp_events_type ev;
   ivp_controller i_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .events_in(events_in),
      .base_load_in(base_load_in), .base_value_in(base_value_in), .level_load_in(level_load_in),
      .level_value_in(level_value_in), .ack_in(ack_in), .ack_vector_in(ack_vector_in), .request_out(request_out),
      .chip_reset_addr_out(chip_reset_addr_out), .watchdog_reset_addr_out(watchdog_reset_addr_out));
   ivp_core_model i_core (.clk_in(core_clk_in), .rst_b_in(rst_b_in), .request_in(request_out),
      .enable_in(core_enable), .delay_in(core_delay), .ack_out(ack_in), .ack_vector_out(ack_vector_in));
   // Clock and a log of every vector the core takes.
   always #25 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) if (ack_in) served.push_back(ack_vector_in);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : compare
   task automatic pulse(input ivp_pkg::ivp_events_type e);
      @(posedge core_clk_in);
      events_in <= e;
      @(posedge core_clk_in);
      events_in <= '0;
   endtask : pulse
   // Lets the core drain all pending work and checks the order it was handed out.
   task automatic serve(input logic [3:0] dly, input ivp_pkg::ivp_vec_type exp[$]);
      int n;
      served.delete();
      core_delay <= dly;
      core_enable <= 1'b1;
      for (n = 0; n < 300 && served.size() < exp.size(); n++) @(posedge core_clk_in);
      repeat (4) @(posedge core_clk_in);
      core_enable <= 1'b0;
      compare(served.size(), exp.size(), "served count");
      foreach (exp[i]) compare(served[i], exp[i], "service order");
      compare(request_out.valid, 1'b0, "idle after service");
   endtask : serve
   task automatic t_reset;
      compare(request_out, '0, "request after reset");
      compare(chip_reset_addr_out, 21'h000000, "chip reset entry");
      compare(watchdog_reset_addr_out, 21'h000002, "watchdog entry");
      $display("test reset done");
   endtask : t_reset
   task automatic t_core;
      ev = '0;
      ev.core_exc = 8'hff;
      ev.timer_ch = 2'h1;
      pulse(ev);
      @(posedge core_clk_in);
      #1;
      compare(request_out, {1'b1, 6'h02, 2'h3, 21'h000004}, "top exception");
      serve(4'h0, '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h19});
      $display("test core order done");
   endtask : t_core
   task automatic t_levels;
      @(posedge core_clk_in);
      level_load_in <= 1'b1;
      level_value_in <= 48'hc000_8001_0000;
      @(posedge core_clk_in);
      level_load_in <= 1'b0;
      ev = '0;
      ev.core_exc[7] = 1'b1;
      ev.rtc_event = 1'b1;
      ev.timer_ch = 2'h3;
      ev.flash_status = 1'b1;
      ev.low_voltage = 1'b1;
      ev.pll_clock_loss = 1'b1;
      ev.pwm_fault = 1'b1;
      ev.cmp_rise[0] = 1'b1;
      ev.gpio_port[5] = 1'b1;
      pulse(ev);
      serve(4'h5, '{6'h09, 6'h21, 6'h19, 6'h12, 6'h0a, 6'h0b, 6'h0e, 6'h0f, 6'h1a, 6'h20});
      $display("test levels done");
   endtask : t_levels
   task automatic t_base;
      @(posedge core_clk_in);
      base_load_in <= 1'b1;
      base_value_in <= 21'h001000;
      @(posedge core_clk_in);
      base_load_in <= 1'b0;
      ev = '0;
      ev.cmp_fall[2] = 1'b1;
      pulse(ev);
      @(posedge core_clk_in);
      #1;
      compare(chip_reset_addr_out, 21'h001000, "moved chip reset entry");
      compare(watchdog_reset_addr_out, 21'h001002, "moved watchdog entry");
      compare(request_out, {1'b1, 6'h11, 2'h0, 21'h001022}, "comparator entry");
      ev = '0;
      ev.pll_lock_loss = 1'b1;
      ev.pwm_reload = 1'b1;
      ev.conv_b_done = 1'b1;
      ev.gpio_port[0] = 1'b1;
      pulse(ev);
      serve(4'h2, '{6'h0b, 6'h0d, 6'h0e, 6'h11, 6'h1b});
      $display("test base done");
   endtask : t_base
   task automatic print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   // Main sequence, and a watchdog far beyond its fewer than two hundred cycles.
   initial begin
      repeat (10) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      #1;
      t_reset;
      t_core;
      t_levels;
      t_base;
      print_verdict;
   end
   initial begin
      #200000;
      failures++;
      print_verdict;
   end
endmodule : test_ivp_controller
bind ivp_controller ivp_controller_assertions i_chk (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
   .events_in(events_in), .base_load_in(base_load_in), .base_value_in(base_value_in),
   .level_load_in(level_load_in), .level_value_in(level_value_in), .ack_in(ack_in), .ack_vector_in(ack_vector_in),
   .request_out(request_out), .chip_reset_addr_out(chip_reset_addr_out),
   .watchdog_reset_addr_out(watchdog_reset_addr_out));
`default_nettype wire
